/* File: rtl/gic_regs.sv */
// Implementation choice: the APB slave port.
`timescale 1ns/1ns
module gic_regs #(
	// capability straps; values are arbitrary build choices
	parameter logic       RMII_PRESENT  = 1'b1,
	parameter logic       MII_PRESENT   = 1'b1,
	parameter logic       PHY_PRESENT   = 1'b1,
	parameter logic [2:0] DIE_REV       = 3'h1,
	parameter logic [2:0] PORTS_MINUS1  = 3'h0,
	parameter logic       LIU_PRESENT   = 1'b1,
	parameter logic       FRAMER_PRESENT = 1'b1,
	parameter logic       ENC_PRESENT   = 1'b1,
	parameter logic       IMUX_PRESENT  = 1'b0
) (
	// clock, reset, enable
	input  wire logic                        pclk,
	input  wire logic                        presetn,
	input  wire logic                        pce,
	// apb slave
	input  wire logic                        psel,
	input  wire logic                        penable,
	input  wire logic                        pwrite,
	input  wire logic [gic_pkg::ADDR_W-1:0]  paddr,
	input  wire logic [gic_pkg::DATA_W-1:0]  pwdata,
	output logic      [gic_pkg::DATA_W-1:0]  prdata,
	output logic                             pready,
	output logic                             pslverr,
	// datapath soft reset
	output logic                             soft_reset,
	// interrupt pin, driven low when active
	input  wire logic                        irq_active,
	output logic                             irq_n_out,
	output logic                             irq_n_oe,
	// reference clock output
	input  wire logic                        ref_clk_src,
	output logic                             ref_clk_out
);
	import gic_pkg::*;

	typedef struct packed {
		logic [2:0]        ctrl;
		logic [1:0]        rst_cnt;
		logic              loaded;
		logic [DATA_W-1:0] rdata;
		logic              irq_n;
		logic              irq_oe;
		logic              ref_out;
	} gic_state_type;

	gic_state_type st_r;
	gic_state_type st_nxt;

	////////////////////////////////////////////////////////////////////////

	function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [5:0] idx);
		hit = (a[1:0] == 2'h0) && (a[ADDR_W-1:2] == idx);
	endfunction

	logic [7:0] id_low;
	logic [7:0] id_high;
	logic       mapped;
	logic       acc;
	logic       wr_take;

	always_comb begin
		id_low                  = 8'h00;                    // [R5]
		id_low[LO_RMII_BIT]     = RMII_PRESENT;             // [R1]
		id_low[LO_MII_BIT]      = MII_PRESENT;              // [R2]
		id_low[LO_PHY_BIT]      = PHY_PRESENT;              // [R3]
		id_low[LO_REV_LSB+:3]   = DIE_REV;                  // [R4]
		id_high                 = 8'h00;                    // [R5]
		id_high[HI_PORTS_LSB+:3] = PORTS_MINUS1;            // [R6]
		id_high[HI_LIU_BIT]     = LIU_PRESENT;              // [R7]
		id_high[HI_FRM_BIT]     = FRAMER_PRESENT;           // [R8]
		id_high[HI_ENC_BIT]     = ENC_PRESENT;              // [R9]
		id_high[HI_IMUX_BIT]    = IMUX_PRESENT;             // [R10]
	end

	assign mapped  = hit(paddr, IDX_ID_LOW) || hit(paddr, IDX_ID_HIGH)
		|| hit(paddr, IDX_CTRL);
	assign acc     = psel && penable;
	// read data is captured a cycle ahead so prdata comes from a flop
	assign pready  = pce && st_r.loaded;
	assign pslverr = acc && pready && !mapped;
	assign wr_take = acc && pready && pwrite && mapped;

	////////////////////////////////////////////////////////////////////////

	always_comb begin
		st_nxt = st_r;
		if (psel && !st_r.loaded) begin
			st_nxt.loaded = 1'b1;
			st_nxt.rdata  = '0;
			if (hit(paddr, IDX_ID_LOW)) begin
				st_nxt.rdata[7:0] = id_low;
			end else if (hit(paddr, IDX_ID_HIGH)) begin
				st_nxt.rdata[7:0] = id_high;
			end else if (hit(paddr, IDX_CTRL)) begin
				st_nxt.rdata[2:0] = st_r.ctrl;
			end
		end
		if (acc && st_r.loaded) begin
			st_nxt.loaded = 1'b0;
		end
		// id writes fall through with no effect
		if (wr_take && hit(paddr, IDX_CTRL)) begin // [R11]
			st_nxt.ctrl = pwdata[2:0];
		end
		// while the reset bit stands, the other control bits hold default
		if (st_nxt.ctrl[CTL_RST_BIT]) begin // [R12]
			st_nxt.ctrl[CTL_REF_BIT]  = CTL_RESET_VAL[CTL_REF_BIT];
			st_nxt.ctrl[CTL_IDLE_BIT] = CTL_RESET_VAL[CTL_IDLE_BIT];
		end
		// stretch so the datapath sees the minimum width even on a short pulse
		if (st_nxt.ctrl[CTL_RST_BIT]) begin // [R12]
			st_nxt.rst_cnt = 2'(RST_MIN_CYC);
		end else if (st_r.rst_cnt != 2'h0) begin
			st_nxt.rst_cnt = st_r.rst_cnt - 2'h1;
		end
		st_nxt.irq_n  = !irq_active;                                  // [R13]
		st_nxt.irq_oe = irq_active || !st_r.ctrl[CTL_IDLE_BIT];       // [R13]
		st_nxt.ref_out = ref_clk_src && !st_r.ctrl[CTL_REF_BIT];      // [R14]
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			st_r         <= '0;
			st_r.ctrl    <= CTL_RESET_VAL;
			st_r.irq_n   <= 1'b1;
			st_r.irq_oe  <= 1'b1;
		end else if (pce) begin
			st_r <= st_nxt;
		end
	end

	assign prdata      = st_r.rdata;
	assign soft_reset  = st_r.rst_cnt != 2'h0;
	assign irq_n_out   = st_r.irq_n;
	assign irq_n_oe    = st_r.irq_oe;
	assign ref_clk_out = st_r.ref_out;

	////////////////////////////////////////////////////////////////////////
	// checks

	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);

	logic rd_lo;
	logic rd_hi;
	assign rd_lo = acc && pready && !pwrite && hit(paddr, IDX_ID_LOW);
	assign rd_hi = acc && pready && !pwrite && hit(paddr, IDX_ID_HIGH);

	// bus events the checks key on
	logic done;
	logic rd_ctl;
	logic wr_ctl;
	logic wr_id;
	assign done   = acc && pready;
	assign rd_ctl = done && !pwrite && hit(paddr, IDX_CTRL);
	assign wr_ctl = wr_take && hit(paddr, IDX_CTRL);
	assign wr_id  = done && pwrite && (hit(paddr, IDX_ID_LOW) || hit(paddr, IDX_ID_HIGH));

	AST_RMII_BIT: assert property (rd_lo |-> prdata[LO_RMII_BIT] == RMII_PRESENT) // [R1]
		else $error("reduced mii flag wrong");
	AST_MII_BIT: assert property (rd_lo |-> prdata[LO_MII_BIT] == MII_PRESENT) // [R2]
		else $error("full mii flag wrong");
	AST_PHY_BIT: assert property (rd_lo |-> prdata[LO_PHY_BIT] == PHY_PRESENT) // [R3]
		else $error("phy flag wrong");
	AST_DIE_REV: assert property (rd_lo |-> prdata[2:0] == DIE_REV) // [R4]
		else $error("die revision wrong");
	AST_RESERVED: assert property ((rd_lo |-> prdata[7:6] == 2'h0) // [R5]
		and (rd_hi |-> prdata[HI_RSV_BIT] == 1'b0))
		else $error("reserved id bit set");
	AST_PORTS: assert property (rd_hi |-> prdata[7:5] == PORTS_MINUS1) // [R6]
		else $error("port count wrong");
	AST_CAPS_HIGH: assert property (rd_hi |-> prdata[4:3] == {LIU_PRESENT, // [R7]
		FRAMER_PRESENT} && prdata[1:0] == {ENC_PRESENT, IMUX_PRESENT}) // [R8]
		else $error("high capability flags wrong");
	AST_ID_READONLY: assert property ((rd_lo || rd_hi) |-> prdata[31:8] == 24'h0 // [R11]
		&& prdata[7:0] == (rd_lo ? id_low : id_high)) // [R9] [R10]
		else $error("id register changed");
	AST_SOFT_RESET: assert property (pce && wr_take && hit(paddr, IDX_CTRL)
		&& pwdata[CTL_RST_BIT] && !soft_reset ##1 pce[*2] |-> soft_reset[*3]) // [R12]
		else $error("soft reset too short");
	AST_RST_CLEARS: assert property (st_r.ctrl[CTL_RST_BIT] |->
		st_r.ctrl[CTL_REF_BIT:CTL_IDLE_BIT] == 2'h0) // [R12]
		else $error("control bits not held at default");
	AST_IRQ_PIN: assert property (pce && irq_active |=> !irq_n_out && irq_n_oe) // [R13]
		else $error("irq pin not driven low");
	AST_IRQ_IDLE: assert property (pce && !irq_active |=>
		irq_n_out && irq_n_oe == !$past(st_r.ctrl[CTL_IDLE_BIT])) // [R13]
		else $error("irq idle mode wrong");
	AST_REF_OFF: assert property (pce && st_r.ctrl[CTL_REF_BIT] |=> !ref_clk_out) // [R14]
		else $error("ref clock not held low");

	////////////////////////////////////////////////////////////////////////
	// per field id checks, one rule each

	AST_LIU_BIT: assert property (rd_hi |-> prdata[HI_LIU_BIT] == LIU_PRESENT) // [R7]
		else $error("line interface flag wrong");

	AST_FRM_BIT: assert property (rd_hi |-> prdata[HI_FRM_BIT] == FRAMER_PRESENT) // [R8]
		else $error("framer flag wrong");

	AST_ENC_BIT: assert property (rd_hi |-> prdata[HI_ENC_BIT] == ENC_PRESENT) // [R9]
		else $error("encapsulation flag wrong");

	AST_IMUX_BIT: assert property (rd_hi |-> prdata[HI_IMUX_BIT] == IMUX_PRESENT) // [R10]
		else $error("inverse mux flag wrong");

	AST_RSV_LOW: assert property (rd_lo |-> prdata[LO_RSV_HI:LO_RSV_LO] == 2'h0) // [R5]
		else $error("low reserved bits set");

	AST_RSV_HIGH: assert property (rd_hi |-> prdata[HI_RSV_BIT] == 1'b0) // [R5]
		else $error("high reserved bit set");

	AST_UPPER_ZERO: assert property (done |-> prdata[DATA_W-1:8] == '0) // [R11]
		else $error("upper read bits set");

	AST_ID_UNDER_RST: assert property (rd_lo && soft_reset |-> prdata[7:0] == id_low) // [R11]
		else $error("id read wrong during soft reset");

	////////////////////////////////////////////////////////////////////////
	// bus timing; read data is loaded in the setup cycle

	AST_RD_CTRL: assert property (rd_ctl |-> // [R11]
		prdata == {{(DATA_W-3){1'b0}}, st_r.ctrl})
		else $error("control readback wrong");

	AST_CTRL_HIGH_ZERO: assert property (rd_ctl |-> prdata[7:3] == 5'h0) // [R11]
		else $error("unused control bits set");

	AST_SETUP_LOW: assert property (pce && psel && !st_r.loaded && hit(paddr, IDX_ID_LOW) // [R11]
		|=> st_r.rdata == {{(DATA_W-8){1'b0}}, id_low})
		else $error("low id not loaded");

	AST_SETUP_HIGH: assert property (pce && psel && !st_r.loaded && hit(paddr, IDX_ID_HIGH) // [R11]
		|=> st_r.rdata == {{(DATA_W-8){1'b0}}, id_high})
		else $error("high id not loaded");

	AST_PREADY_CE: assert property (!pce |-> !pready) // [R11]
		else $error("ready while clock enable low");

	AST_ONE_WAIT: assert property (pce && psel && !st_r.loaded // [R11]
		|=> st_r.loaded)
		else $error("setup did not load");

	AST_READY_DROP: assert property (done |=> !pready) // [R11]
		else $error("ready stuck after transfer");

	AST_ERR_UNMAPPED: assert property (done && !mapped |-> pslverr && prdata == '0) // [R11]
		else $error("unmapped access not refused");

	AST_ERR_MAPPED: assert property (done && mapped |-> !pslverr) // [R11]
		else $error("error on mapped access");

	AST_ERR_ONLY_DONE: assert property (pslverr |-> done) // [R11]
		else $error("error outside access");

	AST_ERR_NO_WRITE: assert property (done && pwrite && !mapped |=> $stable(st_r.ctrl)) // [R11]
		else $error("refused write took effect");

	AST_WR_ID_NO_ERR: assert property (wr_id |-> !pslverr) // [R11]
		else $error("id write flagged as error");

	AST_ID_WR_IGNORED: assert property (wr_id |=> $stable(st_r.ctrl)) // [R11]
		else $error("id write changed control");

	////////////////////////////////////////////////////////////////////////
	// control register and soft reset

	AST_WR_CTRL: assert property (wr_ctl && !pwdata[CTL_RST_BIT] // [R12]
		|=> st_r.ctrl == $past(pwdata[2:0]))
		else $error("control write lost");

	AST_WR_CTRL_RST: assert property (wr_ctl && pwdata[CTL_RST_BIT] |=> st_r.ctrl == 3'h1) // [R12]
		else $error("soft reset did not force defaults");

	AST_CTRL_QUIET: assert property (pce && !wr_ctl |=> $stable(st_r.ctrl)) // [R12]
		else $error("control changed without a write");

	AST_FREEZE_CTRL: assert property (!pce // [R12]
		|=> $stable(st_r.ctrl) && $stable(soft_reset))
		else $error("control moved while frozen");

	AST_FREEZE_PINS: assert property (!pce // [R13] [R14]
		|=> $stable(irq_n_out) && $stable(irq_n_oe) && $stable(ref_clk_out))
		else $error("pins moved while frozen");

	AST_SR_SET: assert property (pce && st_r.ctrl[CTL_RST_BIT] |=> soft_reset) // [R12]
		else $error("soft reset not raised");

	AST_SR_DURING: assert property (pce && st_r.rst_cnt > 2'h1 |=> soft_reset) // [R12]
		else $error("soft reset cut short");

	AST_SR_TAIL: assert property (pce && !st_nxt.ctrl[CTL_RST_BIT] // [R12]
		&& st_r.rst_cnt == 2'h0 |=> !soft_reset)
		else $error("soft reset stuck");

	AST_RST_READBACK: assert property (rd_ctl && st_r.ctrl[CTL_RST_BIT] |-> prdata[2:0] == 3'h1) // [R12]
		else $error("reset bit readback wrong");

	AST_SR_IRQ_DRIVE: assert property (pce && st_r.ctrl[CTL_RST_BIT] |=> irq_n_oe) // [R12]
		else $error("irq idle mode not default in reset");

	AST_SR_REF_RUNS: assert property (pce && st_r.ctrl[CTL_RST_BIT] // [R12]
		|=> ref_clk_out == $past(ref_clk_src))
		else $error("ref clock not default in reset");

	////////////////////////////////////////////////////////////////////////
	// pins; one cycle of latency from input to pin

	AST_IRQ_FOLLOW: assert property (pce |=> irq_n_out == !$past(irq_active)) // [R13]
		else $error("irq pin does not follow");

	AST_IRQ_IDLE_Z: assert property (pce && !irq_active && st_r.ctrl[CTL_IDLE_BIT] // [R13]
		|=> !irq_n_oe)
		else $error("irq pin not released");

	AST_IRQ_IDLE_HI: assert property (pce && !irq_active && !st_r.ctrl[CTL_IDLE_BIT] // [R13]
		|=> irq_n_oe && irq_n_out)
		else $error("irq pin not driven high");

	AST_IRQ_LOW_DRIVEN: assert property (!irq_n_out |-> irq_n_oe) // [R13]
		else $error("active irq not driven");

	AST_IRQ_REL_HIGH: assert property (!irq_n_oe |-> irq_n_out) // [R13]
		else $error("released irq shows active");

	AST_REF_RUN: assert property (pce && !st_r.ctrl[CTL_REF_BIT] // [R14]
		|=> ref_clk_out == $past(ref_clk_src))
		else $error("ref clock not passed");

	COV_READ_ID: cover property (rd_lo ##[1:20] rd_hi);
	COV_SOFT_RESET: cover property (soft_reset ##1 !soft_reset);
	COV_IRQ_TRISTATE: cover property (irq_n_out && !irq_n_oe);
	COV_UNMAPPED: cover property (pslverr);
	COV_CE_STALL: cover property (psel && penable && !pce ##1 pready);

endmodule

/* File: rtl/gic_pkg.sv */
// Overview of operation
// [R1] low id bit 5 flags reduced mii
// [R2] low id bit 4 flags full mii
// [R3] low id bit 3 flags integrated phy
// [R4] low id bits 2:0 die revision count
// [R5] low bits 7:6, high bit 2 reserved
// [R6] high id bits 7:5 ports minus one
// [R7] high id bit 4 flags line interface
// [R8] high id bit 3 flags framer
// [R9] high id bit 1 flags encapsulation
// [R10] high id bit 0 flags inverse mux
// [R11] writes to id registers are ignored
// [R12] control bit 0 resets all but itself
// [R13] irq pin low active, idle per bit 1
// [R14] control bit 2 holds ref clock low
package gic_pkg;

	localparam int ADDR_W = 8;
	localparam int DATA_W = 32;

	// register indices; byte address is four times the index
	localparam logic [5:0] IDX_ID_LOW  = 6'h00;
	localparam logic [5:0] IDX_ID_HIGH = 6'h01;
	localparam logic [5:0] IDX_CTRL    = 6'h02;

	// low identification fields
	localparam int LO_REV_LSB   = 0;
	localparam int LO_PHY_BIT   = 3;
	localparam int LO_MII_BIT   = 4;
	localparam int LO_RMII_BIT  = 5;
	localparam int LO_RSV_LO    = 6;
	localparam int LO_RSV_HI    = 7;

	// high identification fields
	localparam int HI_IMUX_BIT  = 0;
	localparam int HI_ENC_BIT   = 1;
	localparam int HI_RSV_BIT   = 2;
	localparam int HI_FRM_BIT   = 3;
	localparam int HI_LIU_BIT   = 4;
	localparam int HI_PORTS_LSB = 5;

	// control fields
	localparam int CTL_RST_BIT  = 0;
	localparam int CTL_IDLE_BIT = 1;
	localparam int CTL_REF_BIT  = 2;
	localparam logic [2:0] CTL_RESET_VAL = 3'h0;

	// soft reset minimum width
	localparam int CLK_PERIOD_NS = 40;
	localparam int RST_MIN_NS    = 100;
	localparam int RST_MIN_CYC   = (RST_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

endpackage

/* File: testbench/tb_top.sv */
`timescale 1ns/1ns
`define CHK(a, b, m) begin comparisons++; if ((a) !== (b)) begin miscompares++; \
	$display("CHECK FAILED t=%0t %s", $time, m); end end
module tb_top;
	import gic_pkg::*;
	localparam logic [2:0] REV = 3'h5;
	localparam logic [2:0] PRT = 3'h2;
	localparam logic       C_RMII = 1'b1;
	localparam logic       C_MII  = 1'b0;
	localparam logic       C_PHY  = 1'b1;
	localparam logic       C_LIU  = 1'b0;
	localparam logic       C_FRM  = 1'b1;
	localparam logic       C_ENC  = 1'b1;
	localparam logic       C_IMUX = 1'b1;
	// MII, revision, port count, LIU and IMUX straps differ from the defaults so a hardwired value shows up
	localparam logic [7:0] EXP_LO = {2'b00, C_RMII, C_MII, C_PHY, REV};
	localparam logic [7:0] EXP_HI = {PRT, C_LIU, C_FRM, 1'b0, C_ENC, C_IMUX};
	logic        pce_rand;
	logic        pclk, presetn, pce, psel, penable, pwrite, pready, pslverr, er;
	logic        soft_reset, irq_active, irq_n_out, irq_n_oe, ref_clk_src, ref_clk_out, s1;
	logic [7:0]  paddr;
	logic [31:0] pwdata, prdata, rd, w;
	logic [31:0] seed = 32'd1888;
	int          miscompares, comparisons;
	////////////////////////////////////////////////////////////////////////////////
	gic_regs #(.RMII_PRESENT(C_RMII), .MII_PRESENT(C_MII), .PHY_PRESENT(C_PHY), .DIE_REV(REV),
		.PORTS_MINUS1(PRT), .LIU_PRESENT(C_LIU), .FRAMER_PRESENT(C_FRM), .ENC_PRESENT(C_ENC),
		.IMUX_PRESENT(C_IMUX)) dut (.pclk(pclk), .presetn(presetn), .pce(pce), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .soft_reset(soft_reset), .irq_active(irq_active),
		.irq_n_out(irq_n_out), .irq_n_oe(irq_n_oe), .ref_clk_src(ref_clk_src),
		.ref_clk_out(ref_clk_out));
	////////////////////////////////////////////////////////////////////////////////
	function automatic logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction
	// one idle cycle between transfers keeps each signal to one assignment per edge
	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1; penable <= 1'b0; pwrite <= wr; paddr <= a; pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		// only the watchdog ends a wait that never sees pready
		do @(posedge pclk); while (pready !== 1'b1);
		rd = prdata;
		er = pslverr;
		psel <= 1'b0; penable <= 1'b0;
	endtask
	task automatic rchk(input logic [7:0] a, input logic [7:0] e, input logic ee);
		apb(1'b0, a, rnd());
		`CHK(rd, {24'h0, e}, "read data")
		`CHK(er, ee, "slave error")
	endtask
	task test_done;
		$display("miscompares=%0d comparisons=%0d", miscompares, comparisons);
		if (miscompares == 0 && comparisons > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	////////////////////////////////////////////////////////////////////////////////
	initial begin
		pclk = 1'b0;
		forever #20 pclk = ~pclk;
	end
	// source toggles randomly; s1 is what the pin should show one edge later
	always @(posedge pclk) begin
		s1 <= ref_clk_src;
		ref_clk_src <= rnd() & 32'h1;
		pce <= !pce_rand || (rnd() % 3 != 0);
	end
	initial begin
		repeat (3000) @(posedge pclk);
		miscompares++;
		test_done;
	end
	initial begin
		presetn = 1'b0; pce = 1'b1; psel = 1'b0; penable = 1'b0; pwrite = 1'b0;
		paddr = 8'h00; pwdata = 32'h0; irq_active = 1'b0; ref_clk_src = 1'b0;
		pce_rand = 1'b0;
		repeat (3) @(posedge pclk);
		presetn <= 1'b1;
		rchk(8'h00, EXP_LO, 1'b0);
		rchk(8'h04, EXP_HI, 1'b0);
		rchk(8'h08, 8'h00, 1'b0);
		// clock enable stalls transfers at random here
		pce_rand <= 1'b1;
		apb(1'b1, 8'h00, rnd());
		apb(1'b1, 8'h04, rnd());
		rchk(8'h00, EXP_LO, 1'b0);
		rchk(8'h04, EXP_HI, 1'b0);
		pce_rand <= 1'b0;
		foreach (w[i]) if (i < 4) rchk(8'h0c << i, 8'h00, 1'b1);
		rchk(8'h01, 8'h00, 1'b1);
		for (int k = 0; k < 16; k++) begin
			w = rnd() & 32'hffff_fffe;
			apb(1'b1, 8'h08, w);
			rchk(8'h08, {5'h0, w[2:1], 1'b0}, 1'b0);
			irq_active <= w[3];
			repeat (3) @(posedge pclk);
			`CHK(irq_n_out, ~w[3], "irq level")
			`CHK(irq_n_oe, w[3] | ~w[1], "irq drive")
			`CHK(ref_clk_out, w[2] ? 1'b0 : s1, "ref clock")
		end
		// soft reset: bit 0 stays, the other control bits fall back
		irq_active <= 1'b0;
		apb(1'b1, 8'h08, 32'h7);
		@(posedge pclk);
		`CHK(soft_reset, 1'b1, "soft reset on")
		rchk(8'h08, 8'h01, 1'b0);
		`CHK(irq_n_oe, 1'b1, "idle drive in reset")
		rchk(8'h00, EXP_LO, 1'b0);
		apb(1'b1, 8'h08, 32'h0);
		@(posedge pclk);
		`CHK(soft_reset, 1'b1, "minimum width")
		@(posedge pclk);
		`CHK(soft_reset, 1'b1, "soft reset tail")
		@(posedge pclk);
		`CHK(soft_reset, 1'b0, "soft reset off")
		apb(1'b1, 8'h08, 32'h6);
		presetn <= 1'b0;
		repeat (2) @(posedge pclk);
		`CHK(irq_n_oe, 1'b1, "irq drive in reset")
		`CHK(irq_n_out, 1'b1, "irq level in reset")
		`CHK(ref_clk_out, 1'b0, "ref clock in reset")
		`CHK(soft_reset, 1'b0, "soft reset in reset")
		`CHK(pready, 1'b0, "ready in reset")
		presetn <= 1'b1;
		rchk(8'h08, 8'h00, 1'b0);
		test_done;
	end
endmodule
